// ---- rtl/tlc_pkg.sv ----
// Package for the transmit line coder with violation injection.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
package tlc_pkg;
    localparam int TLC_CLK_MHZ = 100;
    localparam int TLC_DIV_RESET = 0;
    localparam int TLC_B8_RUN = 8;
    localparam int TLC_HD_RUN = 4;
    localparam int TLC_SYNC_STAGES = 3;
    localparam int TLC_FIFO_DEPTH = 4;
    localparam int TLC_FIFO_WIDTH = 8;
    localparam logic [1:0] TLC_POL_RESET = 2'h0;
    typedef enum logic [1:0] {
        TLC_MODE_AMI = 2'h0,
        TLC_MODE_B8 = 2'h1,
        TLC_MODE_HD = 2'h2
    } tlc_mode_t;
    typedef enum logic [2:0] {
        TLC_ST_IDLE = 3'h1,
        TLC_ST_ARMED = 3'h2,
        TLC_ST_DONE = 3'h4
    } tlc_inj_t;
endpackage

// ---- rtl/tlc_fifo_if.sv ----
// Interface carrying parallel words from the system side into the coder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface tlc_fifo_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/tlc_fifo.sv ----
// Small synchronous FIFO between the system word bus and the serialiser.
// Assumes the same clock and reset on both sides.
`timescale 1ns/1ns
module tlc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk, // Clock.
    input wire logic resetn, // Synchronous reset, active low.
    tlc_fifo_if.snk wr, // Filling side.
    tlc_fifo_if.src rd // Draining side.
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tlc_fst_t;
    tlc_fst_t s_q, s_d;
    logic [W-1:0] mem [D];
    logic push, pop;
    assign wr.ready = (s_q.cnt != (AW+1)'(D));
    assign rd.valid = (s_q.cnt != '0);
    assign rd.data = mem[s_q.rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : AW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : AW'(s_q.rp + 1'b1);
        end
        s_d.cnt = (AW+1)'(s_q.cnt + push - pop);
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem[s_q.wp] <= wr.data;
        end
    end
    a_fifo_bound: assert property (@(posedge clk) disable iff (!resetn)
        s_q.cnt <= (AW+1)'(D))
        else $error("FIFO count exceeds depth.");
endmodule

// ---- rtl/tlc_coder.sv ----
// Transmit line coder: system words in, dual-rail bipolar pulses out.
// Assumes line_bit_en pulses once per line bit and the inject bit is asynchronous.
`timescale 1ns/1ns
module tlc_coder
    import tlc_pkg::*;
#(
    parameter int W = tlc_pkg::TLC_FIFO_WIDTH,
    parameter int D = tlc_pkg::TLC_FIFO_DEPTH
) (
    input wire logic clk, // 100 MHz clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic line_bit_en, // One-cycle pulse per line bit.
    input wire tlc_pkg::tlc_mode_t line_mode, // Line code select.
    input wire logic inject_bit, // Violation inject control, async.
    input wire logic [W-1:0] sys_word, // Parallel word from system bus.
    input wire logic sys_valid, // Word present.
    output logic sys_ready, // FIFO can take a word.
    output logic tx_positive_rail, // Positive pulse toward line.
    output logic tx_negative_rail, // Negative pulse toward line.
    output logic violation_inject_request // Pending one-shot request.
);
    import tlc_pkg::*;
    localparam int BW = $clog2(W);
    // The 8-bit pipe holds the delayed unipolar bits so substitution can
    // rewrite a zero run once it completes.
    typedef struct packed {
        logic [TLC_SYNC_STAGES-1:0] sync;
        logic lvl;
        tlc_inj_t inj;
        logic [W-1:0] shreg;
        logic [BW-1:0] bcnt;
        logic have;
        logic [7:0] pipe;
        logic [7:0] sub;
        logic [7:0] drop;
        logic [3:0] zrun;
        logic last_mark;
        logic last_viol;
        logic odd;
        logic pos;
        logic neg;
    } tlc_st_t;
    tlc_st_t s_q, s_d;
    tlc_fifo_if #(.W(W)) in_if ();
    tlc_fifo_if #(.W(W)) out_if ();
    logic cur_bit;
    logic [7:0] pipe_n;
    logic sig_b8, sig_hd, arm, inj_done, b, s, dr, p;
    assign in_if.valid = sys_valid;
    assign in_if.data = sys_word;
    assign sys_ready = in_if.ready;
    tlc_fifo #(.W(W), .D(D)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .wr(in_if),
        .rd(out_if)
    );
    // Words are pulled only when the serialiser is empty, so a stalled
    // line lets the FIFO fill and push back on the system side.
    assign out_if.ready = !s_q.have;
    assign cur_bit = s_q.shreg[W-1];
    assign arm = (s_q.inj == TLC_ST_ARMED);
    assign violation_inject_request = arm;
    assign tx_positive_rail = s_q.pos;
    assign tx_negative_rail = s_q.neg;
    always_comb begin
        s_d = s_q;
        inj_done = 1'b0;
        pipe_n = {s_q.pipe[6:0], cur_bit};
        sig_b8 = 1'b0;
        sig_hd = 1'b0;
        b = 1'b0;
        s = 1'b0;
        dr = 1'b0;
        p = 1'b0;
        s_d.sync = {s_q.sync[TLC_SYNC_STAGES-2:0], inject_bit};
        // The level counts only once the last two stages agree.
        if (s_q.sync[2] == s_q.sync[1]) begin
            s_d.lvl = s_q.sync[2];
        end
        if (!s_d.have && out_if.valid) begin
            s_d.have = 1'b1;
            s_d.shreg = out_if.data;
            s_d.bcnt = '0;
        end
        if (line_bit_en && s_q.have) begin
            s_d.shreg = {s_q.shreg[W-2:0], 1'b0};
            s_d.bcnt = BW'(s_q.bcnt + 1'b1);
            if (s_q.bcnt == BW'(W-1)) begin
                s_d.have = 1'b0;
            end
            s_d.sub = {s_q.sub[6:0], 1'b0};
            s_d.drop = {s_q.drop[6:0], 1'b0};
            s_d.pipe = pipe_n;
            s_d.zrun = cur_bit ? 4'h0 : 4'(s_q.zrun + 1'b1);
            // Mark parity is kept on the input side, because the pipe still
            // holds marks that have not reached the line yet.
            s_d.odd = s_q.odd ^ cur_bit;
            if (line_mode == TLC_MODE_B8 && !cur_bit
                && s_q.zrun == 4'(TLC_B8_RUN-1)) begin
                sig_b8 = 1'b1;
                s_d.zrun = 4'h0;
                // Bits 000VB0VB; slot 4 is the first violation.
                s_d.pipe = 8'h1B;
                // Only the two violation slots are marked.
                s_d.sub = 8'h12;
                if (arm) begin
                    s_d.drop = 8'h10;
                    inj_done = 1'b1;
                end
            end
            if (line_mode == TLC_MODE_HD && !cur_bit
                && s_q.zrun == 4'(TLC_HD_RUN-1)) begin
                sig_hd = 1'b1;
                s_d.zrun = 4'h0;
                // Even mark count since last violation: B00V, else 000V.
                s_d.pipe = {s_q.pipe[6:3], !s_q.odd, 3'h1};
                s_d.sub = {s_q.sub[6:3], 4'h1};
                s_d.odd = 1'b0;
                if (arm) begin
                    // Omitting the balancing pulse repeats the polarity.
                    s_d.pipe = {s_q.pipe[6:3], 4'h1};
                    inj_done = 1'b1;
                end
            end
            b = s_d.pipe[7];
            s = s_d.sub[7];
            dr = s_d.drop[7];
            if (b) begin
                if (s) begin
                    // A substituted violation repeats the last pulse.
                    p = s_q.last_mark;
                end else if (line_mode == TLC_MODE_AMI && arm) begin
                    p = s_q.last_mark;
                    inj_done = 1'b1;
                end else begin
                    p = !s_q.last_mark;
                end
                if (dr) begin
                    // A dropped pulse leaves the polarity memory alone.
                    s_d.pos = 1'b0;
                    s_d.neg = 1'b0;
                end else begin
                    s_d.pos = p;
                    s_d.neg = !p;
                    s_d.last_mark = p;
                end
            end else begin
                s_d.pos = 1'b0;
                s_d.neg = 1'b0;
            end
        end else if (line_bit_en) begin
            // Underrun sends spaces and holds the pipe, so a stalled system
            // side never repeats the last pulse on the line.
            s_d.pos = 1'b0;
            s_d.neg = 1'b0;
        end
        case (s_q.inj)
            TLC_ST_IDLE: begin
                if (s_q.sync[2] && s_q.sync[1] && !s_q.lvl) begin
                    s_d.inj = TLC_ST_ARMED;
                end
            end
            TLC_ST_ARMED: begin
                if (inj_done) begin
                    s_d.inj = TLC_ST_DONE;
                end
            end
            TLC_ST_DONE: begin
                if (!s_q.sync[2] && !s_q.sync[1]) begin
                    s_d.inj = TLC_ST_IDLE;
                end
            end
            default: s_d.inj = TLC_ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.inj <= TLC_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
    sequence seq_rise;
        s_q.sync[2] && s_q.sync[1] && !s_q.lvl && s_q.inj == TLC_ST_IDLE;
    endsequence
    a_rise_arms: assert property (@(posedge clk) disable iff (!resetn)
        seq_rise |=> s_q.inj == TLC_ST_ARMED)
        else $error("Rising inject edge did not arm request.");
    a_one_shot: assert property (@(posedge clk) disable iff (!resetn)
        s_q.inj == TLC_ST_DONE |=> s_q.inj != TLC_ST_ARMED)
        else $error("Second violation without re-arming.");
    a_rails_excl: assert property (@(posedge clk) disable iff (!resetn)
        !(tx_positive_rail && tx_negative_rail))
        else $error("Both rails driven together.");
    a_ami_repeat: assert property (@(posedge clk) disable iff (!resetn)
        line_mode == TLC_MODE_AMI && arm && inj_done |=>
        tx_positive_rail == $past(s_q.last_mark)
        && (tx_positive_rail ^ tx_negative_rail))
        else $error("AMI injection did not repeat polarity.");
    a_b8_drop: assert property (@(posedge clk) disable iff (!resetn)
        sig_b8 && arm |=> s_q.drop == 8'h10)
        else $error("Eight-zero injection did not schedule a drop.");
    a_hd_drop: assert property (@(posedge clk) disable iff (!resetn)
        sig_hd && arm |=> s_q.pipe[3:0] == 4'h1)
        else $error("Four-zero injection kept the balancing pulse.");
    a_word_pull: assert property (@(posedge clk) disable iff (!resetn)
        out_if.valid && !s_q.have |=> s_q.have)
        else $error("Serialiser did not take a waiting word.");
    a_clear_arm: assert property (@(posedge clk) disable iff (!resetn)
        arm && inj_done |=> !violation_inject_request)
        else $error("Request stayed set after its violation.");
    sequence seq_ami_mark;
        line_mode == TLC_MODE_AMI && !arm && line_bit_en && s_q.have
        && s_q.pipe[6];
    endsequence
    a_ami_alt: assert property (@(posedge clk) disable iff (!resetn)
        seq_ami_mark |=> tx_positive_rail != $past(s_q.last_mark)
        && (tx_positive_rail ^ tx_negative_rail))
        else $error("AMI mark did not alternate polarity.");
    a_stall_space: assert property (@(posedge clk) disable iff (!resetn)
        line_bit_en && !s_q.have
        |=> !tx_positive_rail && !tx_negative_rail)
        else $error("Underrun did not send a space.");
endmodule

// ---- tb/tlc_line_model.sv ----
// Line-side model: watches the two rails and counts bipolar violations.
// Assumes bit_en marks each line bit and the rails stand for a whole bit.
`timescale 1ns/1ns
module tlc_line_model (
    input wire logic clk, // Clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic bit_en, // Line bit strobe.
    input wire logic pos, // Positive rail.
    input wire logic neg, // Negative rail.
    output logic [15:0] viol_cnt // Violations seen.
);
    logic last_pos_q;
    // Starts as if the last mark was negative, so a positive first mark is legal.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_pos_q <= 1'h0;
            viol_cnt <= 16'h0;
        end else if (bit_en && (pos ^ neg)) begin
            if (pos == last_pos_q) begin
                viol_cnt <= viol_cnt + 16'h1;
            end
            last_pos_q <= pos;
        end
    end
endmodule

// ---- tb/tx_line_code_violation_insert_tb_top.sv ----
// Testbench: streams words through the coder and counts line violations.
// Assumes one clock; the line model does the counting on the rail side.
`timescale 1ns/1ns
module tx_line_code_violation_insert_tb_top;
    import tlc_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic bit_en = 1'h0;
    logic inj = 1'h0;
    logic valid = 1'h0;
    logic [7:0] word = 8'h00;
    tlc_mode_t mode = TLC_MODE_AMI;
    logic ready, pos, neg, req;
    logic stalled = 1'h0;
    logic [1:0] div = 2'h0;
    logic [15:0] viol_cnt;
    logic [15:0] exp_q[$];
    integer seed = 32'h081e;
    int err_count = 0;
    int checks = 0;
    event phase_done;

    tlc_coder #(.W(8), .D(4)) dut_u (.clk(clk), .resetn(resetn),
        .line_bit_en(bit_en), .line_mode(mode), .inject_bit(inj),
        .sys_word(word), .sys_valid(valid), .sys_ready(ready),
        .tx_positive_rail(pos), .tx_negative_rail(neg),
        .violation_inject_request(req));
    tlc_line_model line_u (.clk(clk), .resetn(resetn), .bit_en(bit_en),
        .pos(pos), .neg(neg), .viol_cnt(viol_cnt));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        div <= div + 2'h1;
        bit_en <= (div == 2'h3);
    end

    task automatic test_done();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_cnt(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %0h got %0h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %0h got %0h", n, e, g);
        end
    endtask

    // Holds valid until the edge that takes the word; the caller lowers it.
    task automatic send(input logic [7:0] w);
        int n;
        n = 0;
        valid <= 1'h1;
        word <= w;
        do begin
            @(posedge clk);
            n++;
            if (ready !== 1'h1) begin
                stalled = 1'h1;
            end
            if (n > 500) begin
                err_count++;
                test_done();
            end
        end while (ready !== 1'h1);
    endtask

    task automatic idle(input int n);
        valid <= 1'h0;
        repeat (n) @(posedge clk);
    endtask

    task automatic phase(input tlc_mode_t m, input int sched,
                         input logic [15:0] ev);
        logic [7:0] w;
        resetn <= 1'h0;
        inj <= 1'h0;
        mode <= m;
        idle(10);
        resetn <= 1'h1;
        @(posedge clk);
        chk_bit("rail_pos", 1'h0, pos);
        chk_bit("rail_neg", 1'h0, neg);
        chk_bit("ready", 1'h1, ready);
        // Six data words, then ones so no idle zeros reach the line.
        for (int i = 0; i < 12; i++) begin
            w = (i[0] && i < 6) ? 8'h00 : 8'hFF;
            if (sched == 2) begin
                w = $random(seed) | 8'h81;
            end
            if (sched == 1 && i == 0) begin
                inj <= 1'h1;
            end
            if (sched == 2 && i == 1) begin
                inj <= 1'h1;
                idle(6);
                chk_bit("request", 1'h1, req);
            end
            if (sched == 2 && i == 3) begin
                inj <= 1'h0;
            end
            if (sched == 2 && i == 4) begin
                idle(300);
                chk_bit("request", 1'h0, req);
                inj <= 1'h1;
            end
            send(w);
        end
        valid <= 1'h0;
        repeat (16) @(posedge bit_en);
        exp_q.push_back(ev);
        -> phase_done;
    endtask

    always @(phase_done) begin
        chk_cnt("violations", exp_q.pop_front(), viol_cnt);
    end

    initial begin
        phase(TLC_MODE_AMI, 0, 16'h0);
        phase(TLC_MODE_AMI, 2, 16'h2);
        phase(TLC_MODE_B8, 0, 16'h6);
        phase(TLC_MODE_B8, 1, 16'h5);
        phase(TLC_MODE_HD, 0, 16'h6);
        chk_bit("refused", 1'h1, stalled);
        // Lets the queue checker take the last note before the verdict.
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule
